//--- hdl/adsq_pkg.sv
package adsq_pkg;

   // ****************************************************
   // register word indices (address bits 4..1)
   // ****************************************************
   localparam logic [3:0] REG_INT_STATUS = 4'hA;
   localparam logic [3:0] REG_TIMER      = 4'hB;
   localparam logic [3:0] REG_FIFO       = 4'hC;
   localparam logic [3:0] REG_LIMIT      = 4'hD;

   // ****************************************************
   // field positions
   // ****************************************************
   localparam int INS_PAUSE_BIT  = 0;
   localparam int INS_LOOP_BIT   = 1;
   localparam int INS_SYNC_BIT   = 8;
   localparam int INS_TIMER_BIT  = 9;
   localparam int INS_8BIT_BIT   = 10;
   localparam int INS_WATCH_BIT  = 11;
   localparam int INS_ACQ_LSB    = 12;
   localparam int STAT_FIFO_BIT  = 2;
   localparam int STAT_IP_LSB    = 8;
   localparam int STAT_CNT_LSB   = 11;
   localparam int LIM2_BASE      = 8;

   // ****************************************************
   // reset values and fixed patterns
   // ****************************************************
   localparam logic [15:0] TIMER_PRESET_RST = 16'h0000;
   localparam logic [3:0]  FILL_8BIT        = 4'hE;
   localparam logic [2:0]  IP_RST           = 3'h0;

   // ****************************************************
   // state lengths in core_clk cycles
   // ****************************************************
   localparam int CAL_SHORT_CYC  = 76;
   localparam int ACQ12_BASE     = 9;
   localparam int ACQ8_BASE      = 2;
   localparam int CMP1_CYC       = 5;
   localparam int LIM2_CYC       = 1;
   localparam int CONV12_CYC     = 44;
   localparam int CONV8_CYC      = 21;
   localparam int WATCH_CYC      = 5;
   localparam int TIMER_TAIL_CYC = 2;
   localparam logic [4:0] PRESC_LAST = 5'h1F;

   // gray along fetch-check-cal-timer-acq-cmp1-lim2-final
   typedef enum logic [2:0] {
      ST_FETCH = 3'h0,
      ST_CHECK = 3'h1,
      ST_CALIB = 3'h3,
      ST_TIMER = 3'h2,
      ST_ACQ   = 3'h6,
      ST_CMP1  = 3'h7,
      ST_LIM2  = 3'h5,
      ST_FINAL = 3'h4
   } adsq_state_t;

endpackage

//--- hdl/adsq_core.sv
`timescale 1ns/1ns

// ****************************************************
// result queue: oldest entry leaves first
// ****************************************************
module adsq_fifo
   import adsq_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32,
   parameter int CW    = $clog2(DEPTH + 1)
)(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic      [CW-1:0]    count
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               rd;
      logic [AW-1:0]               wr;
      logic [CW-1:0]               cnt;
   } adsq_fifo_t;

   adsq_fifo_t s;
   adsq_fifo_t next_s;
   logic       do_push;
   logic       do_pop;

   if (DEPTH < 2 || WIDTH < 1)
      $error("adsq_fifo: DEPTH must be at least 2");

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign out_valid = (s.cnt != '0);
   // a pop in the same cycle frees the slot, so full can still accept
   assign in_ready  = (s.cnt != CW'(DEPTH)) || out_ready;
   assign out_data  = s.mem[s.rd];
   assign count     = s.cnt;
   assign do_push   = in_valid && in_ready;
   assign do_pop    = out_valid && out_ready;

   always_comb
   begin
      next_s = s;
      if (do_push)
      begin
         next_s.mem[s.wr] = in_data;
         next_s.wr        = bump(s.wr);
      end
      if (do_pop)
         next_s.rd = bump(s.rd);
      if (do_push && !do_pop)
         next_s.cnt = s.cnt + CW'(1);
      else if (do_pop && !do_push)
         next_s.cnt = s.cnt - CW'(1);
      if (flush)
      begin
         next_s.rd  = '0;
         next_s.wr  = '0;
         next_s.cnt = '0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end
endmodule

module adsq_core
   import adsq_pkg::*;
#(
   parameter int CAL_FULL_CYC = 4944,
   parameter int FIFO_DEPTH   = 32
)(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // parallel host bus
   input  wire logic [4:0]  bus_addr,
   input  wire logic        bus_rd,
   input  wire logic        bus_wr,
   input  wire logic [15:0] bus_wdata,
   output logic      [15:0] bus_rdata,
   input  wire logic        bus_width_select,
   // host signalling
   output logic             transfer_request_out,
   output logic             int_n,
   // configuration and interrupt enable bits
   input  wire logic        cfg_start,
   input  wire logic        cfg_reset,
   input  wire logic        cfg_cal_short,
   input  wire logic        cfg_cal_full,
   input  wire logic        cfg_result_tag,
   input  wire logic        fifo_int_en,
   input  wire logic [4:0]  fifo_threshold,
   // instruction store
   output logic      [2:0]  instruction_pointer,
   input  wire logic [15:0] instr_word,
   // converter side
   input  wire logic        sync_in,
   input  wire logic [12:0] conv_data,
   input  wire logic        cmp1_cross,
   input  wire logic        cmp2_cross
);
   localparam int CW = $clog2(FIFO_DEPTH + 1);

   if (FIFO_DEPTH < 2 || FIFO_DEPTH > 32 || CAL_FULL_CYC < 1 ||
       CAL_FULL_CYC > 8191)
      $error("adsq_core: FIFO_DEPTH 2..32, CAL_FULL_CYC 1..8191");

   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      adsq_state_t st;
      logic [2:0]  ip;
      logic [15:0] ins;
      logic [12:0] dur;
      logic [4:0]  presc;
      logic [15:0] tcnt;
      logic [15:0] preset;
      logic [15:0] lim;
      logic        fifo_flag;
      logic        dma;
      logic        paused;
      logic        pause_ack;
      logic        sync_d;
      logic [CW-1:0] cnt_q;
      logic [15:0] rdata;
   } adsq_core_t;

   adsq_core_t s;
   adsq_core_t next_s;
   logic [1:0] rst_pipe;
   logic       rst_n;

   // ****************************************************
   // reset release
   // ****************************************************
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rst_pipe <= 2'h0;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end
   assign rst_n = rst_pipe[1];

   // ****************************************************
   // queue
   // ****************************************************
   logic          push;
   logic          in_ready;
   logic          out_valid;
   logic          host_pop;
   logic [15:0]   push_word;
   logic [15:0]   head_word;
   logic [CW-1:0] fifo_cnt;
   logic          drop_oldest;

   adsq_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .flush     (cfg_reset),
      .in_valid  (push),
      .in_ready  (in_ready),
      .in_data   (push_word),
      .out_valid (out_valid),
      .out_ready (host_pop || drop_oldest),
      .out_data  (head_word),
      .count     (fifo_cnt)
   );

   // ****************************************************
   // helpers
   // ****************************************************
   function automatic logic [12:0] len(input int cyc);
      len = 13'(cyc - 1);
   endfunction

   // cycles minus one for the state being entered
   function automatic logic [12:0] dur_for(input adsq_state_t st,
                                           input logic [15:0] ins);
      logic [12:0] d2;
      d2 = {8'h00, ins[INS_ACQ_LSB +: 4], 1'b0};
      unique case (st)
         ST_CALIB: dur_for = cfg_cal_full ? len(CAL_FULL_CYC)
                                          : len(CAL_SHORT_CYC);
         ST_TIMER: dur_for = len(TIMER_TAIL_CYC);
         ST_ACQ:   dur_for = d2 + ((ins[INS_8BIT_BIT] ||
                                    ins[INS_WATCH_BIT]) ?
                                   len(ACQ8_BASE) : len(ACQ12_BASE));
         ST_CMP1:  dur_for = len(CMP1_CYC);
         ST_LIM2:  dur_for = len(LIM2_CYC);
         ST_FINAL: dur_for = ins[INS_WATCH_BIT] ? len(WATCH_CYC) :
                             ins[INS_8BIT_BIT]  ? len(CONV8_CYC) :
                                                  len(CONV12_CYC);
         ST_FETCH, ST_CHECK: dur_for = '0;
      endcase
   endfunction

   // bus decode; on the 8-bit bus the high byte completes a word
   logic [3:0] idx;
   logic       word_done;
   logic       sync_edge;
   logic       ins_watch;
   assign idx       = bus_addr[4:1];
   assign word_done = !bus_width_select || bus_addr[0];
   assign host_pop  = bus_rd && idx == REG_FIFO && word_done
                      && out_valid;
   assign sync_edge = sync_in && !s.sync_d;
   assign ins_watch = s.ins[INS_WATCH_BIT];

   // result word assembly
   always_comb
   begin
      push_word[12:4] = conv_data[12:4];
      push_word[3:0]  = s.ins[INS_8BIT_BIT] ? FILL_8BIT
                                            : conv_data[3:0];
      push_word[15:13] = cfg_result_tag ? s.ip
                                        : {3{conv_data[12]}};
   end

   assign push = s.st == ST_FINAL && s.dur == '0 && !ins_watch;
   // full queue: the head leaves as the new word enters
   assign drop_oldest = push && fifo_cnt == CW'(FIFO_DEPTH);

   // ****************************************************
   // sequencer, flags and registers
   // ****************************************************
   logic [15:0] status_word;
   logic [15:0] rd_word;
   logic        fifo_event;
   logic        ends;

   always_comb
   begin
      status_word = '0;
      status_word[STAT_FIFO_BIT] = s.fifo_flag;
      status_word[STAT_IP_LSB +: 3] = s.ip;
      status_word[STAT_CNT_LSB +: 5] = 5'(fifo_cnt);
      unique case (idx)
         REG_INT_STATUS: rd_word = status_word;
         REG_TIMER:      rd_word = s.preset;
         REG_FIFO:       rd_word = out_valid ? head_word : '0;
         REG_LIMIT:      rd_word = s.lim;
         default:        rd_word = '0;
      endcase
   end

   // threshold met on the cycle the count changes onto it
   assign fifo_event = fifo_cnt != s.cnt_q && fifo_threshold != 5'h00 &&
                       fifo_cnt == CW'(fifo_threshold);
   assign ends = s.dur == '0;

   always_comb
   begin
      next_s        = s;
      next_s.sync_d = sync_in;
      next_s.cnt_q  = fifo_cnt;

      // ---------- register access ----------
      if (bus_rd)
      begin
         next_s.rdata = bus_width_select ?
                        {8'h00, bus_addr[0] ? rd_word[15:8] : rd_word[7:0]}
                        : rd_word;
         if (idx == REG_INT_STATUS && word_done)
            next_s.fifo_flag = 1'b0;
         if (idx == REG_LIMIT && word_done)
            next_s.lim = '0;
      end
      if (bus_wr && idx == REG_TIMER)
      begin
         if (!bus_width_select)
            next_s.preset = bus_wdata;
         else if (bus_addr[0])
            next_s.preset[15:8] = bus_wdata[7:0];
         else
            next_s.preset[7:0] = bus_wdata[7:0];
      end

      // ---------- queue flag and transfer request ----------
      if (fifo_event && !s.fifo_flag)
      begin
         next_s.fifo_flag = 1'b1;
         next_s.dma = fifo_int_en;
      end
      else if (fifo_cnt == '0)
         next_s.dma = 1'b0;

      // ---------- sequencer ----------
      if (s.dur != '0)
         next_s.dur = s.dur - 13'h0001;
      unique case (s.st)
         ST_FETCH:
         begin
            next_s.ins = instr_word;
            next_s.st  = ST_CHECK;
         end
         ST_CHECK:
         begin
            if (!cfg_start)
            begin
               next_s.paused = 1'b0;
               next_s.pause_ack = s.paused;
            end
            else if (!s.paused && s.ins[INS_PAUSE_BIT] && !s.pause_ack)
               next_s.paused = 1'b1;
            else if (!s.paused)
            begin
               next_s.pause_ack = 1'b0;
               next_s.presc = '0;
               next_s.tcnt  = s.preset;
               next_s.st = (cfg_cal_short || cfg_cal_full) ? ST_CALIB :
                           s.ins[INS_TIMER_BIT] ? ST_TIMER : ST_ACQ;
               next_s.dur = dur_for(next_s.st, s.ins);
            end
         end
         ST_CALIB:
            if (ends)
            begin
               next_s.st = s.ins[INS_TIMER_BIT] ? ST_TIMER : ST_ACQ;
               next_s.dur = dur_for(next_s.st, s.ins);
            end
         ST_TIMER:
            if (s.tcnt != '0)
            begin
               // tail held until the prescaled count runs out
               next_s.dur   = s.dur;
               next_s.presc = s.presc + 5'h01;
               if (s.presc == PRESC_LAST)
                  next_s.tcnt = s.tcnt - 16'h0001;
            end
            else if (ends)
            begin
               next_s.st  = ST_ACQ;
               next_s.dur = dur_for(ST_ACQ, s.ins);
            end
         ST_ACQ:
            if (ends && (!s.ins[INS_SYNC_BIT] || sync_edge))
            begin
               next_s.st  = ins_watch ? ST_CMP1 : ST_FINAL;
               next_s.dur = dur_for(next_s.st, s.ins);
            end
         ST_CMP1:
            if (ends)
            begin
               if (cmp1_cross)
                  next_s.lim[s.ip] = 1'b1;
               next_s.st  = ST_LIM2;
               next_s.dur = dur_for(ST_LIM2, s.ins);
            end
         ST_LIM2:
            if (ends && (!s.ins[INS_SYNC_BIT] || sync_edge))
            begin
               next_s.st  = ST_FINAL;
               next_s.dur = dur_for(ST_FINAL, s.ins);
            end
         ST_FINAL:
            // start is not looked at here, so a stop still stores
            if (ends && (ins_watch || in_ready))
            begin
               if (ins_watch && cmp2_cross)
                  next_s.lim[LIM2_BASE + 32'(s.ip)] = 1'b1;
               next_s.ip = s.ins[INS_LOOP_BIT] ? IP_RST
                                               : s.ip + 3'h1;
               next_s.st = ST_FETCH;
            end
      endcase

      // reset bit: rest with pointer and flags cleared
      if (cfg_reset)
      begin
         next_s.st        = ST_FETCH;
         next_s.ip        = IP_RST;
         next_s.dur       = '0;
         next_s.fifo_flag = 1'b0;
         next_s.lim       = '0;
         next_s.dma       = 1'b0;
         next_s.paused    = 1'b0;
         next_s.pause_ack = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s        <= '0;
         s.st     <= ST_FETCH;
         s.ip     <= IP_RST;
         s.preset <= TIMER_PRESET_RST;
      end
      else
         s <= next_s;
   end

   // ****************************************************
   // outputs
   // ****************************************************
   assign bus_rdata            = s.rdata;
   assign transfer_request_out = s.dma;
   assign int_n                = !(s.fifo_flag && fifo_int_en);
   assign instruction_pointer  = s.ip;
endmodule

//--- tb/adsq_core_assertions.sv
`timescale 1ns/1ns
// ********
// port checks
// ********
module adsq_core_chk
   import adsq_pkg::*;
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        arst_n,
   // host bus
   input wire logic [4:0]  bus_addr,
   input wire logic        bus_rd,
   input wire logic        bus_wr,
   input wire logic [15:0] bus_wdata,
   input wire logic [15:0] bus_rdata,
   input wire logic        bus_width_select,
   // sequencer
   input wire logic        transfer_request_out,
   input wire logic        int_n,
   input wire logic        cfg_reset,
   input wire logic        fifo_int_en,
   input wire logic [2:0]  instruction_pointer
);
   logic rd16;
   assign rd16 = bus_rd && !bus_width_select;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_req_int_low:
      assert property ($rose(transfer_request_out) |-> fifo_int_en && !int_n)
      else $error("request without interrupt");
   a_ip_steps:
      assert property ($changed(instruction_pointer) |->
         instruction_pointer == 3'h0 ||
         instruction_pointer == 3'($past(instruction_pointer) + 3'h1))
      else $error("pointer jumped");
   a_ip_cleared:
      assert property (cfg_reset |=> instruction_pointer == IP_RST)
      else $error("pointer not cleared");
   a_reset_quiet:
      assert property (cfg_reset |=> !transfer_request_out && int_n)
      else $error("flags survive reset");
   a_unmapped_zero:
      assert property (bus_rd && bus_addr[4:1] < REG_INT_STATUS |=>
         bus_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_byte_high_zero:
      assert property (bus_rd && bus_width_select |=> bus_rdata[15:8] == 8'h00)
      else $error("byte read upper not zero");
   a_status_ip:
      assert property (rd16 && bus_addr[4:1] == REG_INT_STATUS |=>
         bus_rdata[10:8] == $past(instruction_pointer) &&
         (bus_rdata & 16'h00FB) == 16'h0000)
      else $error("status word wrong");
   a_timer_back:
      assert property (rd16 && bus_addr[4:1] == REG_TIMER &&
         $past(bus_wr && !bus_width_select && bus_addr[4:1] == REG_TIMER)
         |=> bus_rdata == $past(bus_wdata, 2))
      else $error("preset read back wrong");
   c_dma: cover property ($rose(transfer_request_out));
   c_wrap: cover property ($past(instruction_pointer) == 3'h7 &&
      instruction_pointer == 3'h0);
   c_byte: cover property (bus_rd && bus_width_select);
endmodule

bind adsq_core adsq_core_chk u_chk (.core_clk, .arst_n, .bus_addr, .bus_rd,
   .bus_wr, .bus_wdata, .bus_rdata, .bus_width_select, .transfer_request_out,
   .int_n, .cfg_reset, .fifo_int_en, .instruction_pointer);

//--- tb/adsq_dma_host.sv
`timescale 1ns/1ns
// ********
// host transfer engine
// ********
module adsq_dma_host
   import adsq_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // device side
   input  wire logic        transfer_request_out,
   input  wire logic [15:0] bus_rdata,
   input  wire logic        slow,
   output logic             dma_rd,
   output logic      [4:0]  dma_addr,
   // delivered results
   output logic             got,
   output logic      [15:0] word
);
   logic [2:0] gap;
   logic       req_q;
   logic       owe;
   logic       pend;

   // gap of 3 keeps a read off the empty queue while the request drops
   always @(posedge core_clk or negedge rst_n)
      if (!rst_n)
      begin
         {dma_rd, dma_addr, gap, req_q, owe, pend, got} <= '0;
         word <= 16'h0000;
      end
      else
      begin
         req_q  <= transfer_request_out;
         pend   <= dma_rd && dma_addr[4:1] == REG_FIFO;
         got    <= pend;
         word   <= bus_rdata;
         dma_rd <= 1'b0;
         if (req_q && !transfer_request_out)
            owe <= 1'b1;
         if (gap != 3'h0)
            gap <= gap - 3'h1;
         else if (owe)
         begin
            owe      <= 1'b0;
            dma_rd   <= 1'b1;
            dma_addr <= {REG_INT_STATUS, 1'b0};
            gap      <= 3'h3;
         end
         else if (transfer_request_out)
         begin
            dma_rd   <= 1'b1;
            dma_addr <= {REG_FIFO, 1'b0};
            gap      <= slow ? 3'h7 : 3'h3;
         end
      end
endmodule

//--- tb/adsq_core_bench.sv
`timescale 1ns/1ns
// ********
// stimulus and checking
// ********
module adsq_core_bench
   import adsq_pkg::*;
;
   logic        core_clk, arst_n, bus_rd, bus_wr, tb_rd, dma_rd, got, req;
   logic        int_n, bw, start, creset, cal, tag, ien, alt, calf, syn;
   logic [4:0]  bus_addr, tb_addr, dma_addr, thr;
   logic [15:0] bus_wdata, bus_rdata, word, ins, v, r, e;
   logic [12:0] cdata;
   logic [2:0]  ip;
   int          miscompares = 0;
   int          tests_run = 0;
   int          seed = 81;
   int          cyc = 0;
   int          nres, base, n, k;

   assign bus_rd   = tb_rd | dma_rd;
   assign bus_addr = dma_rd ? dma_addr : tb_addr;

   adsq_core #(.CAL_FULL_CYC(20), .FIFO_DEPTH(4)) u_dut (.core_clk, .arst_n,
      .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata,
      .bus_width_select(bw), .transfer_request_out(req), .int_n,
      .cfg_start(start), .cfg_reset(creset), .cfg_cal_short(cal),
      .cfg_cal_full(calf), .cfg_result_tag(tag), .fifo_int_en(ien),
      .fifo_threshold(thr), .instruction_pointer(ip),
      .instr_word(ins | (alt && ip[0] ? 16'h0400 : 16'h0000)),
      .sync_in(syn), .conv_data(cdata), .cmp1_cross(1'b0),
      .cmp2_cross(1'b0));
   adsq_dma_host u_dma (.core_clk, .rst_n(arst_n), .transfer_request_out(req),
      .bus_rdata, .slow(tag), .dma_rd, .dma_addr, .got, .word);

   function automatic logic [15:0] expw(input int q);
      logic [2:0] a;
      a = q[2:0];
      return {tag ? a : {3{cdata[12]}}, cdata[12:4],
              a[0] ? FILL_8BIT : cdata[3:0]};
   endfunction

   task automatic check(input string s, input logic [15:0] x, y);
      tests_run++;
      if (y !== x)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", s, x, y);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      tb_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(posedge core_clk);
      #5 bus_wr = 1'b0;
      @(posedge core_clk);
      #5;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      tb_addr = a;
      tb_rd = 1'b1;
      @(posedge core_clk);
      #5 tb_rd = 1'b0;
      d = bus_rdata;
      @(posedge core_clk);
      #5;
   endtask

   task automatic step(output int c);
      logic [2:0] t;
      t = ip;
      c = 0;
      while (ip === t && c < 9000)
      begin
         @(posedge core_clk);
         #5 c++;
      end
   endtask

   task automatic kick();
      creset = 1'b1;
      @(posedge core_clk);
      #5 creset = 1'b0;
      start = 1'b1;
   endtask

   task automatic period(input logic [15:0] w, output int c);
      ins = w;
      kick();
      step(c);
      step(c);
      start = 1'b0;
   endtask

   task automatic halt();
      repeat (20) @(posedge core_clk);
      #5 start = 1'b0;
      repeat (150) @(posedge core_clk);
      #5;
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         summarize();
      end
   end

   always @(posedge core_clk)
      if (got)
      begin
         check("dma word", expw(nres), word);
         nres++;
      end

   initial
   begin
      {arst_n, tb_rd, bus_wr, bw, start, creset, cal, tag, ien, alt} = '0;
      {calf, syn} = '0;
      {tb_addr, bus_wdata, ins, cdata} = '0;
      nres = 0;
      thr = 5'h03;
      repeat (16) @(posedge core_clk);
      #5 arst_n = 1'b1;
      repeat (4) @(posedge core_clk);
      #5 rd(5'h02, r);
      check("unmapped", 16'h0000, r);
      v = $random(seed);
      wr({REG_TIMER, 1'b0}, v);
      rd({REG_TIMER, 1'b0}, r);
      check("preset", v, r);
      n = $random(seed) & 7;
      wr({REG_TIMER, 1'b0}, 16'(n));
      period(16'h0000, base);
      period(16'h0200, k);
      check("timer wait", 16'(32 * n + 2), 16'(k - base));
      period(16'h3000, k);
      check("acq D3", 16'h0006, 16'(k - base));
      period(16'h0400, k);
      check("8-bit", 16'h001E, 16'(base - k));
      cal = 1'b1;
      period(16'h0000, k);
      cal = 1'b0;
      check("calib", 16'h004C, 16'(k - base));
      calf = 1'b1;
      period(16'h0000, k);
      calf = 1'b0;
      check("full calib", 16'h0014, 16'(k - base));
      $display("done durations");
      alt = 1'b1;
      ien = 1'b1;
      for (int p = 0; p < 2; p++)
      begin
         tag = p[0];
         cdata = 13'($random(seed));
         nres = 0;
         kick();
         for (int i = 0; i < 5000 && nres < 12; i++)
            @(posedge core_clk);
         halt();
         $display("done format pass %0d", p);
      end
      ien = 1'b0;
      kick();
      repeat (5) step(k);
      halt();
      rd({REG_INT_STATUS, 1'b0}, r);
      check("count", 16'h0004, {11'h000, r[15:11]});
      rd({REG_FIFO, 1'b0}, r);
      check("oldest lost", expw(2), r);
      bw = 1'b1;
      e = expw(3);
      rd({REG_FIFO, 1'b0}, r);
      check("low byte", {8'h00, e[7:0]}, r);
      rd({REG_FIFO, 1'b1}, r);
      check("high byte", {8'h00, e[15:8]}, r);
      e = expw(4);
      rd({REG_FIFO, 1'b1}, r);
      check("high first", {8'h00, e[15:8]}, r);
      rd({REG_INT_STATUS, 1'b1}, r);
      check("count left", 16'h0001, {11'h000, r[7:3]});
      $display("done queue");
      summarize();
   end
endmodule
